// >>> design/ext_bus_regs.svh
// Constants for the external bus configuration block
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH

// Processor mode field codes
`define MODE_SINGLE 2'h0
`define MODE_EXPAND 2'h1
`define MODE_RESVD 2'h2
`define MODE_MICRO 2'h3

// Mode register 0 field positions
`define PM0_MODE_LO 0
`define PM0_MODE_HI 1
`define PM0_MUX_LO 4
`define PM0_MUX_HI 5
`define PM0_ADDR16 6

// Multiplexed-bus space select codes
`define MUX_NONE 2'h0
`define MUX_CS1 2'h1
`define MUX_CS2 2'h2
`define MUX_ALL 2'h3

// Reset values
`define PM0_MUX_RESET 2'h0
`define PM0_ADDR16_RESET 1'h0
`define EXPAND_RESET 1'h0

// Internal memory sizes in Kbytes
`define RAM_BASE_KB 9'h00f
`define RAM_EXP_KB 9'h014
`define ROM_BASE_KB 9'h0c0
`define ROM_EXP_KB 9'h100

// Chip-select area bounds
`define CS0_LO 20'h30000
`define CS0_HI_EXP 20'hcffff
`define CS0_HI_EXP_BIG 20'hbffff
`define CS0_HI_MICRO 20'hfffff
`define CS1_LO 20'h28000
`define CS1_HI 20'h2ffff
`define CS2_LO 20'h08000
`define CS2_HI 20'h27fff
`define CS3_LO 20'h04000
`define CS3_LO_BIG 20'h06000
`define CS3_HI 20'h07fff

`endif

// >>> design/bus_cfg_pkg.sv
// Types for the external bus configuration block
package bus_cfg_pkg;

  typedef enum logic [1:0] {st_idle, st_addr, st_wait, st_data} bus_state_t;

endpackage

// >>> design/pin_function_map.sv
// Port pin function selection from the bus settings
`timescale 1ns/100ps
`include "ext_bus_regs.svh"

module pin_function_map (
  // Settings
  input wire logic [1:0] mode,
  input wire logic addr16,
  input wire logic mux_all,
  input wire logic byte_pin,
  // Bus function per port group
  output logic p0_bus,
  output logic p1_bus,
  output logic p2_bus,
  output logic p30_bus,
  output logic p3hi_bus,
  output logic p4lo_bus,
  output logic ctrl_bus
);

  logic ext;

  always_comb
  begin
    ext = (mode != `MODE_SINGLE);
    p0_bus = ext && !mux_all;
    p1_bus = ext && !byte_pin && !mux_all;
    p2_bus = ext;
    p30_bus = ext;
    p3hi_bus = ext && !mux_all;
    p4lo_bus = ext && !addr16 && !mux_all;
    ctrl_bus = ext;
  end

endmodule

// >>> design/area_decoder.sv
// Chip-select area decoding for four regions
`timescale 1ns/100ps
`include "ext_bus_regs.svh"

module area_decoder (
  // Lookup
  input wire logic [19:0] addr,
  input wire logic micro,
  input wire logic expanded,
  // Region hits
  output logic [3:0] hit
);

  logic [19:0] lo [4];
  logic [19:0] hi [4];

  always_comb
  begin
    lo[0] = `CS0_LO;
    hi[0] = micro ? `CS0_HI_MICRO : (expanded ? `CS0_HI_EXP_BIG : `CS0_HI_EXP);
    lo[1] = `CS1_LO;
    hi[1] = `CS1_HI;
    lo[2] = `CS2_LO;
    hi[2] = `CS2_HI;
    lo[3] = expanded ? `CS3_LO_BIG : `CS3_LO;
    hi[3] = `CS3_HI;
  end

  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_cs
      assign hit[i] = (addr >= lo[i]) && (addr <= hi[i]);
    end
  endgenerate

endmodule

// >>> design/ext_bus_config.sv
// External bus configuration and access sequencer
`timescale 1ns/100ps
`include "ext_bus_regs.svh"

// Operation
// - Expansion bit clears while reset is asserted
// - Expanded: RAM 20K, ROM 256K
// - Expansion bit changes chip-select areas
// - Single-chip mode ignores the expansion bit
// - Address width bit one: 16-bit address
// - Address width bit zero: 20-bit address
// - Width pin low 16, high 8
// - Separate 8-bit uses P0; 16 adds P1
// - Mode register bits 4,5 pick format
// - Mux 8-bit shares D0-7 with A0-7
// - Mux 16-bit shares D0-7 with A1-8
// - Address latch strobe driven on P56
// - Separate bus wait is optional
// - Reset gives separate bus; no whole-space mux in micro mode
// - Whole-space mux frees P31-P37; the code keeps p3_oe on, so all of P3 stays driven
// - Space field: 00,01/10,11 encoding
module ext_bus_config (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Straps
  input wire logic boot_mode_pin,
  input wire logic data_width_pin,
  input wire logic large_product,
  // Mode register 0 and expansion bit writes
  input wire logic pm0_wr,
  input wire logic [7:0] pm0_wdata,
  input wire logic expand_wr,
  input wire logic internal_area_expand_bit_in,
  output logic [7:0] pm0_rdata,
  output logic internal_area_expand_bit,
  // Chip-select control and wait select
  input wire logic [3:0] cs_enable,
  input wire logic sw_wait_en,
  // Memory map results
  output logic area_expanded,
  output logic [8:0] ram_kb,
  output logic [8:0] rom_kb,
  // Access request
  input wire logic req,
  input wire logic req_write,
  input wire logic [19:0] req_addr,
  input wire logic [15:0] req_wdata,
  output logic bus_ready,
  output logic ack,
  output logic [15:0] rdata,
  // Port pins
  input wire logic [7:0] p0_in,
  output logic [7:0] p0_out,
  output logic p0_oe,
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic p1_oe,
  input wire logic [7:0] p2_in,
  output logic [7:0] p2_out,
  output logic p2_oe,
  input wire logic [7:0] p3_in,
  output logic [7:0] p3_out,
  output logic p3_oe,
  output logic [3:0] p4_out,
  output logic p4_oe,
  output logic [3:0] cs_n,
  output logic ale
);

  bus_cfg_pkg::bus_state_t state_reg, state_next;
  logic [1:0] mode_reg, mode_next;
  logic [1:0] mux_reg, mux_next;
  logic addr16_reg, addr16_next;
  logic expand_reg, expand_next;
  logic strap_reg, strap_next;
  logic [19:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic write_reg, write_next;
  logic mux_acc_reg, mux_acc_next;
  logic [15:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic [7:0] p0_reg, p0_next, p1_reg, p1_next, p2_reg, p2_next;
  logic [7:0] p3_reg, p3_next;
  logic [3:0] p4_reg, p4_next;
  logic [4:0] oe_reg, oe_next;
  logic [3:0] cs_n_reg, cs_n_next;
  logic ale_reg, ale_next;
  logic expand_eff, mux_all_eff, taken, is_mux;
  logic fn_p0, fn_p1, fn_p2, fn_p30, fn_p3hi, fn_p4, fn_ctrl;
  logic [3:0] hit;

  //----------------------------------------
  // Settings in effect
  //----------------------------------------
  always_comb
  begin
    expand_eff = expand_reg && large_product && (mode_reg != `MODE_SINGLE);
    mux_all_eff = (mux_reg == `MUX_ALL) && (mode_reg == `MODE_EXPAND);
    area_expanded = expand_eff;
    ram_kb = expand_eff ? `RAM_EXP_KB : `RAM_BASE_KB;
    rom_kb = expand_eff ? `ROM_EXP_KB : `ROM_BASE_KB;
    pm0_rdata = 8'h00;
    pm0_rdata[`PM0_MODE_HI:`PM0_MODE_LO] = mode_reg;
    pm0_rdata[`PM0_MUX_HI:`PM0_MUX_LO] = mux_reg;
    pm0_rdata[`PM0_ADDR16] = addr16_reg;
    internal_area_expand_bit = expand_reg;
  end

  pin_function_map u_pin_map (
    .mode(mode_reg),
    .addr16(addr16_reg),
    .mux_all(mux_all_eff),
    .byte_pin(data_width_pin),
    .p0_bus(fn_p0),
    .p1_bus(fn_p1),
    .p2_bus(fn_p2),
    .p30_bus(fn_p30),
    .p3hi_bus(fn_p3hi),
    .p4lo_bus(fn_p4),
    .ctrl_bus(fn_ctrl)
  );

  area_decoder u_area (
    .addr(req_addr),
    .micro(mode_reg == `MODE_MICRO),
    .expanded(expand_eff),
    .hit(hit)
  );

  //----------------------------------------
  // Configuration registers
  //----------------------------------------
  always_comb
  begin
    mode_next = mode_reg;
    mux_next = mux_reg;
    addr16_next = addr16_reg;
    expand_next = expand_reg;
    strap_next = 1'b1;
    if (!strap_reg)
    begin
      mode_next = boot_mode_pin ? `MODE_MICRO : `MODE_SINGLE;
    end
    else if (pm0_wr)
    begin
      if (pm0_wdata[`PM0_MODE_HI:`PM0_MODE_LO] != `MODE_RESVD)
      begin
        mode_next = pm0_wdata[`PM0_MODE_HI:`PM0_MODE_LO];
      end
      mux_next = pm0_wdata[`PM0_MUX_HI:`PM0_MUX_LO];
      addr16_next = pm0_wdata[`PM0_ADDR16];
    end
    if (strap_reg && expand_wr)
    begin
      expand_next = internal_area_expand_bit_in;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      mode_reg <= `MODE_SINGLE;
      mux_reg <= `PM0_MUX_RESET;
      addr16_reg <= `PM0_ADDR16_RESET;
      expand_reg <= `EXPAND_RESET;
      strap_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      mux_reg <= mux_next;
      addr16_reg <= addr16_next;
      expand_reg <= expand_next;
      strap_reg <= strap_next;
    end
  end

  //----------------------------------------
  // Access sequencer
  //----------------------------------------
  always_comb
  begin
    bus_ready = strap_reg && fn_ctrl && (state_reg == bus_cfg_pkg::st_idle);
    taken = req && bus_ready;
    is_mux = mux_all_eff || ((mux_reg == `MUX_CS1) && hit[1]) ||
             ((mux_reg == `MUX_CS2) && hit[2]);
    state_next = state_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    write_next = write_reg;
    mux_acc_next = mux_acc_reg;
    rdata_next = rdata_reg;
    ack_next = 1'b0;
    case (state_reg)
      bus_cfg_pkg::st_idle:
      begin
        if (taken)
        begin
          addr_next = req_addr;
          wdata_next = req_wdata;
          write_next = req_write;
          mux_acc_next = is_mux;
          state_next = bus_cfg_pkg::st_addr;
        end
      end
      bus_cfg_pkg::st_addr:
      begin
        if (mux_acc_reg || sw_wait_en)
        begin
          state_next = bus_cfg_pkg::st_wait;
        end
        else
        begin
          state_next = bus_cfg_pkg::st_data;
        end
      end
      bus_cfg_pkg::st_wait:
      begin
        state_next = bus_cfg_pkg::st_data;
      end
      default:
      begin
        state_next = bus_cfg_pkg::st_idle;
        ack_next = 1'b1;
        if (write_reg)
        begin
          rdata_next = rdata_reg;
        end
        else if (!mux_acc_reg)
        begin
          rdata_next = {data_width_pin ? 8'h00 : p1_in, p0_in};
        end
        else if (data_width_pin)
        begin
          rdata_next = {8'h00, p2_in};
        end
        else
        begin
          rdata_next = {p1_in, p3_in[0], p2_in[7:1]};
        end
      end
    endcase
  end

  //----------------------------------------
  // Pin drive
  //----------------------------------------
  always_comb
  begin
    p0_next = wdata_next[7:0];
    p1_next = wdata_next[15:8];
    p2_next = addr_next[7:0];
    p3_next = addr_next[15:8];
    p4_next = addr_next[19:16];
    if (mux_acc_next && (state_next == bus_cfg_pkg::st_data))
    begin
      if (data_width_pin)
      begin
        p2_next = wdata_next[7:0];
      end
      else
      begin
        p2_next[7:1] = wdata_next[6:0];
        p3_next[0] = wdata_next[7];
      end
    end
    oe_next[0] = fn_p0 && write_next && !mux_acc_next &&
                 (state_next == bus_cfg_pkg::st_data);
    oe_next[1] = fn_p1 && write_next && (state_next == bus_cfg_pkg::st_data);
    oe_next[2] = fn_p2 && !(mux_acc_next && !write_next &&
                 (state_next == bus_cfg_pkg::st_data));
    oe_next[3] = fn_p30 || fn_p3hi;
    oe_next[4] = fn_p4;
    ale_next = fn_ctrl && mux_acc_next && (state_next == bus_cfg_pkg::st_addr);
    cs_n_next = 4'hf;
    if (fn_ctrl && taken)
    begin
      cs_n_next = ~(hit & cs_enable);
    end
    else if (state_next != bus_cfg_pkg::st_idle)
    begin
      cs_n_next = cs_n_reg;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= bus_cfg_pkg::st_idle;
      addr_reg <= 20'h00000;
      wdata_reg <= 16'h0000;
      write_reg <= 1'b0;
      mux_acc_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      ack_reg <= 1'b0;
      p0_reg <= 8'h00;
      p1_reg <= 8'h00;
      p2_reg <= 8'h00;
      p3_reg <= 8'h00;
      p4_reg <= 4'h0;
      oe_reg <= 5'h00;
      cs_n_reg <= 4'hf;
      ale_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      write_reg <= write_next;
      mux_acc_reg <= mux_acc_next;
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      p0_reg <= p0_next;
      p1_reg <= p1_next;
      p2_reg <= p2_next;
      p3_reg <= p3_next;
      p4_reg <= p4_next;
      oe_reg <= oe_next;
      cs_n_reg <= cs_n_next;
      ale_reg <= ale_next;
    end
  end

  assign ack = ack_reg;
  assign rdata = rdata_reg;
  assign p0_out = p0_reg;
  assign p1_out = p1_reg;
  assign p2_out = p2_reg;
  assign p3_out = p3_reg;
  assign p4_out = p4_reg;
  assign {p4_oe, p3_oe, p2_oe, p1_oe, p0_oe} = oe_reg;
  assign cs_n = cs_n_reg;
  assign ale = ale_reg;

  //----------------------------------------
  // Checks
  //----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  expand_clear_a: assert property (!strap_reg |-> !expand_reg)
    else $error("expansion bit set before strap capture");
  single_expand_a: assert property (mode_reg == `MODE_SINGLE |->
    !area_expanded && ram_kb == `RAM_BASE_KB && rom_kb == `ROM_BASE_KB)
    else $error("single-chip mode shows expanded area");
  big_map_a: assert property (expand_reg && large_product && mode_reg == `MODE_EXPAND
    |-> ram_kb == `RAM_EXP_KB && rom_kb == `ROM_EXP_KB)
    else $error("expanded sizes wrong");
  addr16_p4_a: assert property (addr16_reg && $past(addr16_reg) |-> !p4_oe)
    else $error("upper address driven in 16-bit mode");
  addr20_p4_a: assert property (mode_reg == `MODE_MICRO && !addr16_reg &&
    $past(mode_reg) == `MODE_MICRO && !$past(addr16_reg) |-> p4_oe)
    else $error("upper address not driven in 20-bit mode");
  byte_p1_a: assert property (data_width_pin && $past(data_width_pin) |-> !p1_oe)
    else $error("P1 driven with 8-bit width");
  ale_mux_a: assert property (ale |-> mux_acc_reg ##1 !ale)
    else $error("latch strobe outside mux address phase");
  mux_wait_a: assert property (state_reg == bus_cfg_pkg::st_addr && mux_acc_reg
    |=> state_reg == bus_cfg_pkg::st_wait)
    else $error("mux access without wait");
  micro_sep_a: assert property (taken && mode_reg == `MODE_MICRO &&
    mux_reg == `MUX_ALL |=> !mux_acc_reg && !ale)
    else $error("whole-space mux in microprocessor mode");
  mode_valid_a: assert property (mode_reg != `MODE_RESVD)
    else $error("reserved processor mode stored");
  single_quiet_a: assert property (mode_reg == `MODE_SINGLE &&
    $past(mode_reg) == `MODE_SINGLE |-> oe_reg == 5'h00 && !ale && !bus_ready)
    else $error("bus pins active in single-chip mode");
  ack_time_a: assert property (req && bus_ready |-> ##[3:4] ack)
    else $error("access not acknowledged in time");

  mux_access_c: cover property (req && bus_ready && is_mux ##[3:4] ack);
  sep_access_c: cover property (req && bus_ready && !is_mux ##3 ack);
  expand_on_c: cover property (area_expanded);

endmodule

// >>> test/ext_memory_model.sv
// Behavioural external memory on the far side of the bus pins
`timescale 1ns/100ps

module ext_memory_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Pins from the device
  input wire logic [3:0] cs_n,
  input wire logic [7:0] p2_out,
  input wire logic [7:0] p3_out,
  input wire logic p0_oe,
  input wire logic p1_oe,
  input wire logic p2_oe,
  // Data back to the device
  output logic [7:0] p0_in,
  output logic [7:0] p1_in,
  output logic [7:0] p2_in
);
  logic [15:0] addr_reg;
  logic [15:0] last_reg;
  logic sel_reg;
  logic sel;
  logic [15:0] data;

  assign sel = (cs_n != 4'hf);
  assign data = addr_reg ^ 16'h5a5a;
  // Released lines show the inverse of the last value
  assign p0_in = (sel && !p0_oe) ? data[7:0] : ~last_reg[7:0];
  assign p1_in = (sel && !p1_oe) ? data[15:8] : ~last_reg[15:8];
  assign p2_in = (sel && !p2_oe) ? data[7:0] : ~last_reg[7:0];

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      addr_reg <= 16'h0000;
      last_reg <= 16'h0000;
      sel_reg <= 1'b0;
    end
    else
    begin
      sel_reg <= sel;
      if (sel && !sel_reg)
        addr_reg <= {p3_out, p2_out};
      if (sel)
        last_reg <= data;
    end
  end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the external bus configuration block
`timescale 1ns/100ps

module tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic boot_mode_pin = 1'b0;
  logic data_width_pin = 1'b1;
  logic large_product = 1'b1;
  logic pm0_wr = 1'b0;
  logic [7:0] pm0_wdata = 8'h00;
  logic expand_wr = 1'b0;
  logic internal_area_expand_bit_in = 1'b0;
  logic [3:0] cs_enable = 4'hf;
  logic sw_wait_en = 1'b0;
  logic req = 1'b0;
  logic req_write = 1'b0;
  logic [19:0] req_addr = 20'h00000;
  logic [15:0] req_wdata = 16'h0000;
  logic [7:0] p3_in = 8'h00;
  logic [7:0] p0_in, p1_in, p2_in, pm0_rdata, p0_out, p1_out, p2_out, p3_out;
  logic internal_area_expand_bit, area_expanded, bus_ready, ack, ale;
  logic p0_oe, p1_oe, p2_oe, p3_oe, p4_oe;
  logic [8:0] ram_kb, rom_kb;
  logic [15:0] rdata;
  logic [3:0] p4_out, cs_n;
  int miscompares = 0;
  int comparisons = 0;
  int lat;
  logic [7:0] s_p0 [0:7], s_p1 [0:7], s_p2 [0:7], s_p3 [0:7];
  logic [3:0] s_cs [0:7], s_p4 [0:7];
  logic s_ale [0:7], s_p0oe [0:7], s_p1oe [0:7], s_p4oe [0:7];

  always #25 clock = ~clock;

  ext_bus_config uut (
    .clock, .rst, .boot_mode_pin, .data_width_pin, .large_product, .pm0_wr, .pm0_wdata,
    .expand_wr, .internal_area_expand_bit_in, .pm0_rdata, .internal_area_expand_bit,
    .cs_enable, .sw_wait_en, .area_expanded, .ram_kb, .rom_kb, .req, .req_write,
    .req_addr, .req_wdata, .bus_ready, .ack, .rdata, .p0_in, .p0_out, .p0_oe, .p1_in,
    .p1_out, .p1_oe, .p2_in, .p2_out, .p2_oe, .p3_in, .p3_out, .p3_oe, .p4_out, .p4_oe,
    .cs_n, .ale
  );

  ext_memory_model mem (
    .clock, .rst, .cs_n, .p2_out, .p3_out, .p0_oe, .p1_oe, .p2_oe, .p0_in, .p1_in, .p2_in
  );

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check_val(input logic [19:0] got, input logic [19:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: value %h, expected %h", $time, got, exp);
    end
  endtask

  task check_lat(input int got, input int exp);
    comparisons++;
    if (got != exp)
    begin
      miscompares++;
      $display("unexpected at %0t: latency %0d, expected %0d", $time, got, exp);
    end
  endtask

  task wrap_up();
    $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task do_reset(input logic bm, input logic bw);
    rst = 1'b1;
    boot_mode_pin = bm;
    data_width_pin = bw;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    repeat (2) @(negedge clock);
  endtask

  task pm0_write(input logic [7:0] d);
    pm0_wr = 1'b1;
    pm0_wdata = d;
    @(negedge clock);
    pm0_wr = 1'b0;
    repeat (2) @(negedge clock);
  endtask

  task expand_write(input logic b);
    expand_wr = 1'b1;
    internal_area_expand_bit_in = b;
    @(negedge clock);
    expand_wr = 1'b0;
    repeat (2) @(negedge clock);
  endtask

  task refused_req();
    req = 1'b1;
    repeat (5)
    begin
      @(negedge clock);
      check_val(ack, 1'b0);
    end
    req = 1'b0;
  endtask

  // Records the pins after each edge until the done pulse
  task access(input logic wr, input logic [19:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (bus_ready !== 1'b1 && n < 20)
    begin
      @(negedge clock);
      n++;
    end
    req = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    lat = 0;
    while (ack !== 1'b1 && lat < 7)
    begin
      // Index 1 is the address phase right after the take edge
      @(posedge clock);
      #1;
      lat++;
      s_p0[lat] = p0_out;
      s_p1[lat] = p1_out;
      s_p2[lat] = p2_out;
      s_p3[lat] = p3_out;
      s_p4[lat] = p4_out;
      s_cs[lat] = cs_n;
      s_ale[lat] = ale;
      s_p0oe[lat] = p0_oe;
      s_p1oe[lat] = p1_oe;
      s_p4oe[lat] = p4_oe;
      @(negedge clock);
      req = 1'b0;
    end
    @(negedge clock);
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    do_reset(1'b0, 1'b1);
    check_val(internal_area_expand_bit, 1'b0);
    check_val(pm0_rdata, 8'h00);
    check_val({bus_ready, p0_oe, p1_oe, p2_oe, p3_oe, p4_oe, ale, cs_n}, 11'h00f);
    refused_req();
    expand_write(1'b1);
    check_val({area_expanded, ram_kb, rom_kb}, {1'b0, 9'h00f, 9'h0c0});
    pm0_write(8'h02);
    check_val(pm0_rdata, 8'h00);
    pm0_write(8'h01);
    check_val({area_expanded, ram_kb, rom_kb}, {1'b1, 9'h014, 9'h100});
    access(1'b0, 20'hd0000, 16'h0000);
    check_val(s_cs[1], 4'hf);
    access(1'b0, 20'h05000, 16'h0000);
    check_val(s_cs[1][3], 1'b1);
    expand_write(1'b0);
    access(1'b0, 20'h05000, 16'h0000);
    check_val(s_cs[1][3], 1'b0);
    access(1'b0, 20'h28010, 16'h0000);
    check_lat(lat, 3);
    check_val({s_cs[1], s_p4oe[1], s_p4[1]}, {4'hd, 1'b1, 4'h2});
    check_val({s_p1oe[2], rdata[7:0]}, {1'b0, 8'h4a});
    sw_wait_en = 1'b1;
    access(1'b0, 20'h28010, 16'h0000);
    check_lat(lat, 4);
    sw_wait_en = 1'b0;
    pm0_write(8'h41);
    access(1'b0, 20'h28010, 16'h0000);
    check_val({s_p4oe[1], s_p3[1], s_p2[1]}, {1'b0, 8'h80, 8'h10});
    pm0_write(8'h11);
    check_val(pm0_rdata, 8'h11);
    sw_wait_en = 1'b1;
    access(1'b1, 20'h28012, 16'h00c3);
    check_lat(lat, 4);
    check_val({s_ale[1], s_ale[2], s_p2[1], s_p2[3]}, {2'b10, 16'h12c3});
    sw_wait_en = 1'b0;
    pm0_write(8'h21);
    access(1'b1, 20'h28012, 16'h00c3);
    check_lat(lat, 3);
    check_val(s_ale[1], 1'b0);
    pm0_write(8'h31);
    access(1'b0, 20'h08012, 16'h0000);
    check_lat(lat, 4);
    check_val({s_ale[1], s_p0oe[3], rdata[7:0]}, {2'b10, 8'h48});
    pm0_write(8'h00);
    check_val({bus_ready, p0_oe, p2_oe, p4_oe}, 4'h0);
    expand_write(1'b1);
    do_reset(1'b1, 1'b0);
    check_val({internal_area_expand_bit, pm0_rdata}, {1'b0, 8'h03});
    access(1'b1, 20'h28010, 16'h1234);
    check_val({s_p1oe[2], s_p1[2], s_p0[2]}, {1'b1, 16'h1234});
    access(1'b0, 20'h28010, 16'h0000);
    check_val(rdata, 16'hda4a);
    pm0_write(8'h33);
    access(1'b0, 20'h28010, 16'h0000);
    check_lat(lat, 3);
    pm0_write(8'h13);
    access(1'b1, 20'h28012, 16'h12c3);
    check_val({s_p3[1][0], s_p2[1][7:1]}, 8'h09);
    check_val({s_p3[3][0], s_p2[3][7:1], s_p1[3]}, 16'hc312);
    wrap_up();
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    miscompares++;
    $display("unexpected at %0t: run did not finish", $time);
    wrap_up();
  end
endmodule
